// ===== logic/bbuc_pkg.sv
// Shared constants, modes and pin bundle for the bidirectional bus up/down counter.
package bbuc_pkg;

	// ------------------------------------------------------------
	// Counter geometry
	// ------------------------------------------------------------
	localparam int               CNT_W      = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX    = 8'hFF;
	localparam logic [CNT_W-1:0] CNT_STEP   = 8'h01;

	// ------------------------------------------------------------
	// Clocking and synchroniser depth
	// ------------------------------------------------------------
	localparam int               MCLK_PERIOD_NS = 100;
	localparam int               SYNC_STAGES    = 2;
	localparam logic [1:0]       RST_ASSERTED   = 2'h0;
	localparam logic [1:0]       RST_RELEASED   = 2'h3;

	// ------------------------------------------------------------
	// Operating modes chosen at each counter clock edge
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		MODE_HOLD  = 5'h01,
		MODE_CLEAR = 5'h02,
		MODE_LOAD  = 5'h04,
		MODE_UP    = 5'h08,
		MODE_DOWN  = 5'h10
	} bbuc_mode_e;

	// ------------------------------------------------------------
	// Pin bundle passed through the input synchroniser
	// ------------------------------------------------------------
	typedef struct packed {
		logic             sync_clear_n;
		logic             chip_sel_n;
		logic             load_en_n;
		logic             out_en_n;
		logic             count_en_par_n;
		logic             count_en_trk_n;
		logic             count_up;
		logic             count_clk;
		logic [CNT_W-1:0] data;
	} bbuc_pins_s;

endpackage

// ===== logic/bbuc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ps
module bbuc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	if (W < 1) begin : g_bad_width
		$error("bbuc_sync: W must be at least 1");
	end

	// ------------------------------------------------------------
	// First stage feeds only the second stage.
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ===== logic/bbuc_top.sv
// Eight-stage up/down counter sharing one three-state bus for load data and count output.
`timescale 1ns/1ps
// Summary of operation
// - The count is an eight-bit register that changes only on a rising counter clock edge, except for the asynchronous clear and the reset.
// - The count is driven onto the bus only when chip select is low, load enable is high and output enable is low.
// - Chip select high releases the bus and disables the load enable whatever else is applied.
// - Async clear low empties the count at once without a clock edge and overrides every other input.
// - Sync clear low empties the count on a clock edge ahead of load, hold and count.
// - Chip select and load enable both low load the count from the bus on a clock edge, ignoring count enables and direction.
// - With no clear or load, parallel count enable high holds the count.
// - With no clear or load, trickle count enable high holds the count and keeps final count high.
// - With both count enables low the count steps up by one when direction is high and down by one when low.
// - An active-low final count output lets counters be cascaded through their count enables.
module bbuc_top
	import bbuc_pkg::*;
#(
	parameter int CNT_WIDTH = CNT_W
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             async_clear_n,
	input  wire logic             sync_clear_n,
	input  wire logic             chip_sel_n,
	input  wire logic             load_en_n,
	input  wire logic             out_en_n,
	input  wire logic             count_en_par_n,
	input  wire logic             count_en_trk_n,
	input  wire logic             count_up,
	input  wire logic             count_clk,
	input  wire logic [CNT_W-1:0] bus_i,
	output logic      [CNT_W-1:0] bus_o,
	output logic                  bus_oe,
	output logic                  final_count_n
);

	if (CNT_WIDTH != CNT_W) begin : g_bad_width
		$error("bbuc_top: CNT_WIDTH must equal the package counter width");
	end

	// ------------------------------------------------------------
	// Terminal decode, shared by the output and its check.
	// ------------------------------------------------------------
	function automatic logic is_terminal(input logic [CNT_W-1:0] v, input logic up);
		is_terminal = up ? (v == CNT_MAX) : (v == CNT_ZERO);
	endfunction

	// ------------------------------------------------------------
	// Reset and asynchronous clear synchronisers
	// ------------------------------------------------------------
	logic [1:0]       rst_n_q;
	logic [1:0]       clr_n_q;
	logic             rst_n;
	logic             clr_n;
	logic             clr_arst_n;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_n_q <= RST_ASSERTED;
		end else begin
			rst_n_q <= {rst_n_q[0], 1'b1};
		end
	end

	assign rst_n      = rst_n_q[1];
	assign clr_arst_n = rst_n & async_clear_n;

	// The clear asserts with no clock edge and releases after two mclk edges.
	// immediate asynchronous clear
	always_ff @(posedge mclk or negedge clr_arst_n) begin
		if (!clr_arst_n) begin
			clr_n_q <= RST_ASSERTED;
		end else begin
			clr_n_q <= {clr_n_q[0], 1'b1};
		end
	end

	assign clr_n = clr_n_q[1];

	// ------------------------------------------------------------
	// Pin synchroniser and counter clock edge detect
	// ------------------------------------------------------------
	bbuc_pins_s pins_raw;
	bbuc_pins_s pins;
	logic       cclk_prev_q;
	logic       clk_rise;

	assign pins_raw = '{
		sync_clear_n:   sync_clear_n,
		chip_sel_n:     chip_sel_n,
		load_en_n:      load_en_n,
		out_en_n:       out_en_n,
		count_en_par_n: count_en_par_n,
		count_en_trk_n: count_en_trk_n,
		count_up:       count_up,
		count_clk:      count_clk,
		data:           bus_i
	};

	bbuc_sync #(
		.W ($bits(bbuc_pins_s))
	) u_sync (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (pins_raw),
		.q     (pins)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cclk_prev_q <= 1'b0;
		end else begin
			cclk_prev_q <= pins.count_clk;
		end
	end

	assign clk_rise = pins.count_clk & ~cclk_prev_q;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic       do_clear;
	logic       do_load;
	logic       do_hold;
	bbuc_mode_e mode;

	assign do_clear = ~pins.sync_clear_n;
	assign do_load  = ~pins.chip_sel_n & ~pins.load_en_n;
	assign do_hold  = pins.count_en_par_n | pins.count_en_trk_n;

	assign mode = do_clear       ? MODE_CLEAR :
	              do_load        ? MODE_LOAD  :
	              do_hold        ? MODE_HOLD  :
	              pins.count_up  ? MODE_UP    : MODE_DOWN;

	// ------------------------------------------------------------
	// Count register
	// ------------------------------------------------------------
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;

	always_comb begin
		case (mode)
			MODE_CLEAR: begin
				count_d = CNT_ZERO;
			end
			MODE_LOAD: begin
				count_d = pins.data;
			end
			MODE_UP: begin
				count_d = count_q + CNT_STEP;
			end
			MODE_DOWN: begin
				count_d = count_q - CNT_STEP;
			end
			default: begin
				count_d = count_q;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge clr_n) begin
		if (!clr_n) begin
			count_q <= CNT_ZERO;
		end else if (clk_rise) begin
			count_q <= count_d;
		end
	end

	// ------------------------------------------------------------
	// Bus drive and final count
	// ------------------------------------------------------------
	logic bus_oe_q;
	logic bus_oe_d;
	logic fc_n_q;
	logic fc_n_d;

	assign bus_oe_d = ~pins.chip_sel_n & pins.load_en_n & ~pins.out_en_n;

	assign fc_n_d = ~(~pins.count_en_trk_n & is_terminal(count_q, pins.count_up));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_oe_q <= 1'b0;
		end else begin
			bus_oe_q <= bus_oe_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fc_n_q <= 1'b1;
		end else begin
			fc_n_q <= fc_n_d;
		end
	end

	assign bus_o         = count_q;
	assign bus_oe        = bus_oe_q;
	assign final_count_n = fc_n_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_NO_EDGE_NO_CHANGE: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		!clk_rise |=> (count_q == $past(count_q))
	) else $error("count changed without a counter clock edge");

	AST_BUS_DRIVE: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!pins.chip_sel_n && pins.load_en_n && !pins.out_en_n) |=> bus_oe
	) else $error("bus not driven although output selected");

	AST_CS_RELEASES: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pins.chip_sel_n |=> !bus_oe
	) else $error("bus driven while chip select high");

	AST_ASYNC_CLEAR: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!async_clear_n ##1 !async_clear_n) |-> (count_q == CNT_ZERO)
	) else $error("count not cleared while async clear low");

	AST_SYNC_CLEAR: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && !pins.sync_clear_n) |=> (count_q == CNT_ZERO)
	) else $error("sync clear did not empty the count");

	AST_LOAD: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && pins.sync_clear_n && !pins.chip_sel_n && !pins.load_en_n)
		|=> (count_q == $past(pins.data))
	) else $error("load did not take the bus value");

	AST_HOLD: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && pins.sync_clear_n && (pins.chip_sel_n || pins.load_en_n)
			&& (pins.count_en_par_n || pins.count_en_trk_n)) |=> $stable(count_q)
	) else $error("count moved in hold");

	AST_TRICKLE_HIGH: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pins.count_en_trk_n |=> final_count_n
	) else $error("final count low while trickle enable high");

	AST_COUNT_STEP: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && pins.sync_clear_n && (pins.chip_sel_n || pins.load_en_n)
			&& !pins.count_en_par_n && !pins.count_en_trk_n && pins.count_up)
		|=> (count_q == CNT_W'($past(count_q) + CNT_STEP))
	) else $error("count up did not add one");

	AST_COUNT_DOWN: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && pins.sync_clear_n && (pins.chip_sel_n || pins.load_en_n)
			&& !pins.count_en_par_n && !pins.count_en_trk_n && !pins.count_up)
		|=> (count_q == CNT_W'($past(count_q) - CNT_STEP))
	) else $error("count down did not subtract one");

	AST_FINAL_COUNT: assert property (
		@(posedge mclk) disable iff (!rst_n)
		rst_n |=> (final_count_n == !(!$past(pins.count_en_trk_n)
			&& is_terminal($past(count_q), $past(pins.count_up))))
	) else $error("final count does not match terminal decode");

	AST_WRAP_UP: assert property (
		@(posedge mclk) disable iff (!rst_n || !clr_n)
		(clk_rise && mode == MODE_UP && count_q == CNT_MAX) |=> (count_q == CNT_ZERO)
	) else $error("count did not wrap to zero");

endmodule

// ===== testbench/bbuc_bus_model.sv
// Controller-side model of the shared three-state bus wire.
`timescale 1ns/1ps
module bbuc_bus_model
	import bbuc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic [CNT_W-1:0] bus_o,
	input  wire logic             bus_oe,
	input  wire logic             drv_en,
	input  wire logic [CNT_W-1:0] drv_val,
	output logic      [CNT_W-1:0] bus_w
);
	logic [CNT_W-1:0] last_q = 8'h5A;

	// A released wire shows a pattern that changes every cycle, never a stale value.
	always_ff @(posedge mclk) begin
		last_q <= bus_w;
	end

	assign bus_w = bus_oe ? bus_o : (drv_en ? drv_val : ~last_q);
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the bidirectional bus up/down counter.
`timescale 1ns/1ps
module testbench
	import bbuc_pkg::*;
;
	logic             mclk, nrst, async_clear_n, drv_en;
	logic             bus_oe, final_count_n;
	logic [CNT_W-1:0] bus_o, bus_w;
	bbuc_pins_s       pins;
	int               fails, comparisons;

	bbuc_top bbuc_top_i (
		.mclk(mclk), .nrst(nrst), .async_clear_n(async_clear_n), .sync_clear_n(pins.sync_clear_n),
		.chip_sel_n(pins.chip_sel_n), .load_en_n(pins.load_en_n), .out_en_n(pins.out_en_n),
		.count_en_par_n(pins.count_en_par_n), .count_en_trk_n(pins.count_en_trk_n),
		.count_up(pins.count_up), .count_clk(pins.count_clk), .bus_i(bus_w), .bus_o(bus_o),
		.bus_oe(bus_oe), .final_count_n(final_count_n)
	);

	bbuc_bus_model bbuc_bus_model_i (
		.mclk(mclk), .bus_o(bus_o), .bus_oe(bus_oe), .drv_en(drv_en), .drv_val(pins.data), .bus_w(bus_w)
	);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input string name, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Settles the controls, then gives one counter clock pulse within the allowed spacing.
	task automatic pulse(input logic cs_n, input logic ld_n, input logic par_n, input logic trk_n, input logic up);
		pins.chip_sel_n = cs_n;
		pins.load_en_n = ld_n;
		pins.count_en_par_n = par_n;
		pins.count_en_trk_n = trk_n;
		pins.count_up = up;
		drv_en = !cs_n && !ld_n;
		tick(4);
		pins.count_clk = 1'b1;
		tick(4);
		pins.count_clk = 1'b0;
		tick(4);
	endtask

	task automatic close_out();
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #(MCLK_PERIOD_NS / 2) mclk = ~mclk;
	end

	initial begin
		#(MCLK_PERIOD_NS * 5000);
		fails++;
		close_out();
	end

	initial begin
		fails = 0;
		comparisons = 0;
		nrst = 1'b0;
		async_clear_n = 1'b1;
		drv_en = 1'b0;
		pins = {7'h7F, 1'b0, 8'hFE};
		repeat (4) @(posedge mclk);
		#1;
		nrst = 1'b1;
		tick(6);
		chk("bus_oe", 8'h00, {7'h00, bus_oe});
		pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("bus_o", 8'hFE, bus_o);
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		chk("bus_o", 8'hFF, bus_o);
		chk("final_count_n", 8'h00, {7'h00, final_count_n});
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		chk("bus_o", 8'h00, bus_o);
		pins.count_up = 1'b0;
		tick(4);
		chk("final_count_n", 8'h00, {7'h00, final_count_n});
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("bus_o", 8'hFF, bus_o);
		pulse(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		chk("bus_o", 8'hFF, bus_o);
		chk("final_count_n", 8'h01, {7'h00, final_count_n});
		pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
		chk("bus_o", 8'hFF, bus_o);
		chk("final_count_n", 8'h01, {7'h00, final_count_n});
		pins.data = 8'h33;
		pulse(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("bus_o", 8'hFE, bus_o);
		pins.sync_clear_n = 1'b0;
		pins.data = 8'h77;
		pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		chk("bus_o", 8'h00, bus_o);
		pins.sync_clear_n = 1'b1;
		pins.data = 8'h5A;
		pulse(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		chk("bus_o", 8'h5B, bus_o);
		tick(12);
		chk("bus_o", 8'h5B, bus_o);
		for (int i = 0; i < 8; i++) begin
			if (i[2:1] == 2'b00) begin
				continue;
			end
			{pins.chip_sel_n, pins.load_en_n, pins.out_en_n} = i[2:0];
			tick(5);
			chk("bus_oe", {7'h00, i[2:0] == 3'h2}, {7'h00, bus_oe});
			if (i[2:0] == 3'h2) begin
				chk("bus_w", 8'h5B, bus_w);
			end
		end
		pins.out_en_n = 1'b1;
		async_clear_n = 1'b0;
		#20;
		chk("bus_o", 8'h00, bus_o);
		tick(2);
		chk("bus_o", 8'h00, bus_o);
		async_clear_n = 1'b1;
		tick(4);
		pulse(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		chk("bus_o", 8'h01, bus_o);
		close_out();
	end
endmodule
